/* File: hdl/fxb_exec.sv */
// Execution stage for invert, clear, decrement, skip and jump.
// Assumes inputs synchronous to clk_sys; op is valid while op_valid.
`timescale 1ns/1ps
`include "fxb_defines.svh"
// Contract
// - Destination bit 0 writes accumulator, 1 file
// - Invert writes inverse, updates zero flag
// - Clear file writes zero, sets zero flag
// - Clear accumulator writes zero, sets zero
// - Decrement writes f minus one, updates zero
// - Decrement skip discards next on zero
// - Increment skip discards next on zero
// - Jump loads literal into pc bits 10:0
// - Jump fills pc 14:11 from latch 6:3
// - Jump takes two cycles, flags kept
module fxb_exec
    import fxb_pkg::*;
(
    input  wire logic                      clk_sys,
    input  wire logic                      nrst,
    input  wire logic                      clk_en,
    input  wire logic                      op_valid,
    input  wire fxb_pkg::fxb_op_e          op,
    input  wire logic [`FXB_ADDR_W-1:0]    file_addr,
    input  wire logic                      dest_file,
    input  wire fxb_pkg::fxb_byte_t        file_data,
    input  wire logic [`FXB_LIT_W-1:0]     jump_literal,
    input  wire logic [`FXB_LATCH_W-1:0]   pc_high_latch,
    output logic                           accum_we,
    output fxb_pkg::fxb_byte_t             accum_data,
    output logic                           file_we,
    output logic [`FXB_ADDR_W-1:0]         file_waddr,
    output fxb_pkg::fxb_byte_t             file_wdata,
    output logic                           zero_flag,
    output logic                           pc_load,
    output fxb_pkg::fxb_pc_t               pc_target,
    output logic                           busy
);
    import fxb_pkg::*;

    fxb_result_if res ();             // ALU result bundle
    logic         stall_reg;          // Second cycle of a two-cycle instruction
    logic         take;               // Instruction accepted this cycle
    logic         writes_dest;        // Instruction writes a byte
    logic         to_file;            // Byte goes to the file register
    logic         skip_op;            // Skip family

    // Builds the jump target from literal and latch bits
    // Used for the target only; the checks restate the literal and latch bit fields themselves
    function automatic fxb_pc_t jump_pc(input logic [`FXB_LIT_W-1:0] lit,
                                        input logic [`FXB_LATCH_W-1:0] latch);
        jump_pc = {latch[`FXB_LATCH_HI:`FXB_LATCH_LO], lit};
    endfunction

    // Pure combinational leaf; every timing decision stays in this module
    fxb_alu u_alu
    (
        .op      (op),
        .operand (file_data),
        .res     (res)
    );

    // The slot after a zero-result skip or a jump is a no-op; a new op is ignored then
    assign take        = clk_en && op_valid && !stall_reg;
    assign skip_op     = (op == FXB_OP_DEC_SKIP_ZERO) || (op == FXB_OP_INC_SKIP_ZERO);
    // Only the six file operations write a byte; NONE, jump and unused codes write nothing
    assign writes_dest = op inside {FXB_OP_INVERT_FILE, FXB_OP_ZERO_FILE, FXB_OP_ZERO_ACCUM,
                                    FXB_OP_DEC_FILE, FXB_OP_DEC_SKIP_ZERO, FXB_OP_INC_SKIP_ZERO};
    // Clear file always targets the file; clear accumulator never does
    always_comb
    begin
        unique case (op)
            FXB_OP_ZERO_FILE:  to_file = 1'b1;
            FXB_OP_ZERO_ACCUM: to_file = 1'b0;
            default:           to_file = dest_file;
        endcase
    end

    // Destination write strobes and data; strobes last one enabled cycle and hold while clk_en is low
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            accum_we   <= 1'b0;
            file_we    <= 1'b0;
            accum_data <= `FXB_ZERO_BYTE;
            file_wdata <= `FXB_ZERO_BYTE;
            file_waddr <= '0;
        end
        else if (clk_en)
        begin
            accum_we   <= take && writes_dest && !to_file;
            file_we    <= take && writes_dest && to_file;
            if (take && writes_dest)
            begin
                accum_data <= res.value;
                file_wdata <= res.value;
                file_waddr <= file_addr;
            end
        end
    end

    // Zero flag; skip and jump leave it alone
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            zero_flag <= 1'b0;
        else if (clk_en && take && writes_dest && !skip_op)
            zero_flag <= res.is_zero;
    end

    // Two-cycle sequencing: jumps always, skips only on a zero result
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            stall_reg <= 1'b0;
        else if (clk_en)
            stall_reg <= take && ((op == FXB_OP_JUMP_LITERAL)
                         || (skip_op && res.is_zero));
    end
    // busy is its own flop beside stall_reg so the output stays registered;
    // both load the same expression, so they can never disagree

    // Program counter load for jumps
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pc_load   <= 1'b0;
            pc_target <= `FXB_PC_RESET;
            busy      <= 1'b0;
        end
        else if (clk_en)
        begin
            pc_load <= take && (op == FXB_OP_JUMP_LITERAL);
            busy    <= take && ((op == FXB_OP_JUMP_LITERAL) || (skip_op && res.is_zero));
            if (take && (op == FXB_OP_JUMP_LITERAL))
                pc_target <= jump_pc(jump_literal, pc_high_latch);
        end
    end

    // Checks
    chk_skip_two_cycle: assert property (@(posedge clk_sys) disable iff (!nrst)
        (take && op == FXB_OP_DEC_SKIP_ZERO && res.is_zero) |=> busy)
        else $error("decrement skip did not stall");
    chk_inc_skip: assert property (@(posedge clk_sys) disable iff (!nrst)
        (take && op == FXB_OP_INC_SKIP_ZERO && res.is_zero) |=> busy)
        else $error("increment skip did not stall");
    chk_skip_keeps_z: assert property (@(posedge clk_sys) disable iff (!nrst)
        (take && skip_op) |=> $stable(zero_flag))
        else $error("skip changed zero flag");
    chk_jump_target: assert property (@(posedge clk_sys) disable iff (!nrst)
        (take && op == FXB_OP_JUMP_LITERAL) |=>
        (pc_load && pc_target[`FXB_LIT_W-1:0] == $past(jump_literal)))
        else $error("jump literal wrong");
    chk_jump_high: assert property (@(posedge clk_sys) disable iff (!nrst)
        (take && op == FXB_OP_JUMP_LITERAL) |=>
        (pc_target[`FXB_PC_W-1:`FXB_LIT_W] == $past(pc_high_latch[6:3])))
        else $error("jump high bits wrong");
    chk_jump_flags: assert property (@(posedge clk_sys) disable iff (!nrst)
        (take && op == FXB_OP_JUMP_LITERAL) |=> (busy && $stable(zero_flag)))
        else $error("jump not two cycles or changed flag");
    chk_clear_sets_z: assert property (@(posedge clk_sys) disable iff (!nrst)
        (take && op == FXB_OP_ZERO_FILE) |=> (zero_flag && file_we && file_wdata == 8'h00))
        else $error("clear file wrong");
    chk_clearw: assert property (@(posedge clk_sys) disable iff (!nrst)
        (take && op == FXB_OP_ZERO_ACCUM) |=> (zero_flag && accum_we && !file_we))
        else $error("clear accumulator wrong");
    chk_dest_sel: assert property (@(posedge clk_sys) disable iff (!nrst)
        (take && op == FXB_OP_DEC_FILE && !dest_file) |=> (accum_we && !file_we))
        else $error("destination select wrong");
    chk_zero_match: assert property (@(posedge clk_sys) disable iff (!nrst)
        (take && (op == FXB_OP_INVERT_FILE || op == FXB_OP_DEC_FILE)) |=>
        (zero_flag == (accum_we ? accum_data == 8'h00 : file_wdata == 8'h00)))
        else $error("zero flag mismatch");
    chk_nonzero_skip: assert property (@(posedge clk_sys) disable iff (!nrst)
        (take && skip_op && !res.is_zero) |=> !busy)
        else $error("nonzero skip stalled");

    // Result values and file destinations, compared with the operand and address as they were sampled at the take
    chk_invert_value: assert property (@(posedge clk_sys) disable iff (!nrst)
        (take && op == FXB_OP_INVERT_FILE) |=>
        ((accum_we ? accum_data : file_wdata) == fxb_byte_t'(~$past(file_data))))
        else $error("invert result wrong");
    chk_dec_value: assert property (@(posedge clk_sys) disable iff (!nrst)
        (take && op == FXB_OP_DEC_FILE) |=>
        ((accum_we ? accum_data : file_wdata) == fxb_byte_t'($past(file_data) - `FXB_ONE_BYTE)))
        else $error("decrement result wrong");
    chk_dec_skip_value: assert property (@(posedge clk_sys) disable iff (!nrst)
        (take && op == FXB_OP_DEC_SKIP_ZERO) |=>
        ((accum_we ? accum_data : file_wdata) == fxb_byte_t'($past(file_data) - `FXB_ONE_BYTE)))
        else $error("decrement skip result wrong");
    chk_inc_value: assert property (@(posedge clk_sys) disable iff (!nrst)
        (take && op == FXB_OP_INC_SKIP_ZERO) |=>
        ((accum_we ? accum_data : file_wdata) == fxb_byte_t'($past(file_data) + `FXB_ONE_BYTE)))
        else $error("increment skip result wrong");
    chk_dest_file: assert property (@(posedge clk_sys) disable iff (!nrst)
        (take && writes_dest && to_file) |=>
        (file_we && !accum_we && file_waddr == $past(file_addr)))
        else $error("file destination wrong");
    chk_clear_file_dest: assert property (@(posedge clk_sys) disable iff (!nrst)
        (take && op == FXB_OP_ZERO_FILE) |=> (!accum_we && file_waddr == $past(file_addr)))
        else $error("clear file address wrong");

    // Steps of the skip and jump behaviours; the properties below chain them
    sequence jump_taken;
        take && op == FXB_OP_JUMP_LITERAL;
    endsequence
    sequence zero_skip_taken;
        take && skip_op && res.is_zero;
    endsequence
    sequence nonzero_skip_taken;
        take && skip_op && !res.is_zero;
    endsequence
    sequence noop_slot;
        clk_en && busy;
    endsequence
    sequence next_write_offered;
        clk_en && op_valid && writes_dest;
    endsequence

    // An op offered in the slot after a two-cycle instruction must vanish; one offered after a nonzero skip must execute
    chk_skip_slot_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
        zero_skip_taken ##1 noop_slot |=> !(accum_we || file_we || pc_load || busy))
        else $error("op in skip slot was executed");
    chk_jump_slot_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
        jump_taken ##1 noop_slot |=> !(accum_we || file_we || pc_load || busy))
        else $error("op in jump slot was executed");
    chk_nonzero_next: assert property (@(posedge clk_sys) disable iff (!nrst)
        nonzero_skip_taken ##1 next_write_offered |=> (accum_we || file_we))
        else $error("op after nonzero skip was dropped");
endmodule

/* File: hdl/fxb_defines.svh */
// Constants for the file-op and branch execution block.
// Assumes inclusion by bare name from hdl/.
`ifndef FXB_DEFINES_SVH
`define FXB_DEFINES_SVH
`define FXB_DATA_W     8
`define FXB_ADDR_W     7
`define FXB_LIT_W      11
`define FXB_PC_W       15
`define FXB_LATCH_W    7
`define FXB_LATCH_LO   3
`define FXB_LATCH_HI   6
`define FXB_ZERO_BYTE  8'h00
`define FXB_ONE_BYTE   8'h01
`define FXB_PC_RESET   15'h0000
`define FXB_CLK_MHZ    250
`endif

/* File: hdl/fxb_pkg.sv */
// Types shared by the execution block and its operand port.
// Assumes fxb_defines.svh is reachable by bare name.
`include "fxb_defines.svh"
package fxb_pkg;
    // Instruction selector presented by the decoder upstream
    typedef enum logic [3:0]
    {
        FXB_OP_NONE,
        FXB_OP_INVERT_FILE,
        FXB_OP_ZERO_FILE,
        FXB_OP_ZERO_ACCUM,
        FXB_OP_DEC_FILE,
        FXB_OP_DEC_SKIP_ZERO,
        FXB_OP_INC_SKIP_ZERO,
        FXB_OP_JUMP_LITERAL
    } fxb_op_e;
    typedef logic [`FXB_DATA_W-1:0] fxb_byte_t;
    typedef logic [`FXB_PC_W-1:0]   fxb_pc_t;
endpackage

/* File: hdl/fxb_result_if.sv */
// Carries one computed result from the ALU leaf to the sequencer.
// Assumes both ends share clk_sys.
`timescale 1ns/1ps
interface fxb_result_if;
    import fxb_pkg::*;
    fxb_byte_t value;      // Computed byte
    logic      is_zero;    // Value equals zero
    modport producer (output value, output is_zero);
    modport consumer (input value, input is_zero);
endinterface

/* File: hdl/fxb_alu.sv */
// Combinational arithmetic for the file operations.
// Assumes the operand byte is already read from the file.
`timescale 1ns/1ps
`include "fxb_defines.svh"
module fxb_alu
    import fxb_pkg::*;
(
    input  wire fxb_pkg::fxb_op_e  op,
    input  wire fxb_pkg::fxb_byte_t operand,
    fxb_result_if.producer          res
);
    // Result per instruction; unused codes yield the operand
    always_comb
    begin
        unique case (op)
            FXB_OP_INVERT_FILE:   res.value = ~operand;
            FXB_OP_ZERO_FILE,
            FXB_OP_ZERO_ACCUM:    res.value = `FXB_ZERO_BYTE;
            FXB_OP_DEC_FILE,
            FXB_OP_DEC_SKIP_ZERO: res.value = operand - `FXB_ONE_BYTE;
            FXB_OP_INC_SKIP_ZERO: res.value = operand + `FXB_ONE_BYTE;
            default:              res.value = operand;
        endcase
        res.is_zero = (res.value == `FXB_ZERO_BYTE);
    end
endmodule

/* File: bench/tb_cpu_file_op_and_branch_exec.sv */
// Self-checking bench for the file-op and branch execution stage.
// Assumes fxb_pkg and fxb_exec are compiled first; one clock, no partner.
`timescale 1ns/1ps
module tb_cpu_file_op_and_branch_exec;
    import fxb_pkg::*;
    logic        clk_sys, nrst, clk_en, op_valid, dest_file;
    fxb_op_e     op;
    logic [6:0]  file_addr, pc_high_latch;
    fxb_byte_t   file_data, accum_data, file_wdata;
    logic [10:0] jump_literal;
    logic        accum_we, file_we, zero_flag, pc_load, busy;
    logic [6:0]  file_waddr;
    fxb_pc_t     pc_target;
    // Reference state, mirrors what the outputs must show
    logic        e_awe, e_fwe, e_zero, e_pcl, e_busy;
    fxb_byte_t   e_adata, e_fdata;
    logic [6:0]  e_faddr;
    fxb_pc_t     e_pct;
    int          fail_count, comparisons;

    fxb_exec dut (.clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en), .op_valid(op_valid),
        .op(op), .file_addr(file_addr), .dest_file(dest_file), .file_data(file_data),
        .jump_literal(jump_literal), .pc_high_latch(pc_high_latch), .accum_we(accum_we),
        .accum_data(accum_data), .file_we(file_we), .file_waddr(file_waddr),
        .file_wdata(file_wdata), .zero_flag(zero_flag), .pc_load(pc_load),
        .pc_target(pc_target), .busy(busy));

    // 250 MHz system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic cmp_flag(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask

    task automatic cmp_val(input string what, input logic [14:0] exp, input logic [14:0] got);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Result byte of a file operation; clears give zero
    function automatic fxb_byte_t calc(input fxb_op_e o, input fxb_byte_t f);
        case (o)
            FXB_OP_INVERT_FILE:                    return ~f;
            FXB_OP_DEC_FILE, FXB_OP_DEC_SKIP_ZERO: return f - 8'h01;
            FXB_OP_INC_SKIP_ZERO:                  return f + 8'h01;
            default:                               return 8'h00;
        endcase
    endfunction

    // One edge of the reference; reads inputs as the design samples them
    task automatic model_step();
        fxb_byte_t r;
        logic      wr, to_file, nb;
        r = calc(op, file_data);
        wr = op inside {[FXB_OP_INVERT_FILE:FXB_OP_INC_SKIP_ZERO]};
        to_file = (op == FXB_OP_ZERO_FILE) || (op != FXB_OP_ZERO_ACCUM && dest_file);
        nb = 1'b0;
        // Frozen clock enable holds every register, strobes included
        if (!clk_en) return;
        {e_awe, e_fwe, e_pcl} = 3'h0;
        // An op offered in the no-op slot is dropped
        if (op_valid && !e_busy)
        begin
            if (wr && to_file) {e_fwe, e_faddr, e_fdata} = {1'b1, file_addr, r};
            if (wr && !to_file) {e_awe, e_adata} = {1'b1, r};
            if (op inside {FXB_OP_INVERT_FILE, FXB_OP_DEC_FILE}) e_zero = (r == 8'h00);
            if (op inside {FXB_OP_ZERO_FILE, FXB_OP_ZERO_ACCUM}) e_zero = 1'b1;
            if (op == FXB_OP_JUMP_LITERAL)
                {e_pcl, e_pct} = {1'b1, pc_high_latch[6:3], jump_literal};
            nb = (op == FXB_OP_JUMP_LITERAL) || (r == 8'h00 && op inside
                 {FXB_OP_DEC_SKIP_ZERO, FXB_OP_INC_SKIP_ZERO});
        end
        e_busy = nb;
    endtask

    // Bytes near the zero boundary are favoured so skips really fire
    task automatic drive_random();
        clk_en <= ($urandom_range(0, 7) != 0);
        op_valid <= ($urandom_range(0, 4) != 0);
        op <= fxb_op_e'(4'($urandom_range(0, 8)));
        file_addr <= 7'($urandom);
        dest_file <= 1'($urandom);
        case ($urandom_range(0, 5))
            0: file_data <= 8'h00;
            1: file_data <= 8'h01;
            2: file_data <= 8'hff;
            default: file_data <= 8'($urandom);
        endcase
        jump_literal <= ($urandom_range(0, 3) == 0) ? 11'h7ff : 11'($urandom);
        pc_high_latch <= 7'($urandom);
    endtask

    // Hand-made opening: zero-result skips and a full jump, each with an op in its slot
    task automatic drive_corner(input int k);
        clk_en <= 1'b1;
        op_valid <= 1'b1;
        dest_file <= k[0];
        file_addr <= 7'h7f;
        file_data <= (k == 2) ? 8'hff : 8'h01;
        jump_literal <= 11'h7ff;
        pc_high_latch <= 7'h78;
        case (k)
            0: op <= FXB_OP_DEC_SKIP_ZERO;
            1: op <= FXB_OP_INVERT_FILE;
            2: op <= FXB_OP_INC_SKIP_ZERO;
            3: op <= FXB_OP_DEC_FILE;
            4: op <= FXB_OP_JUMP_LITERAL;
            default: op <= FXB_OP_ZERO_ACCUM;
        endcase
    endtask

    // Reset with a check that all outputs sit at zero meanwhile
    task automatic do_reset(input int n);
        nrst <= 1'b0;
        op_valid <= 1'b0;
        repeat (n) @(posedge clk_sys);
        #1;
        cmp_flag("reset strobes", 1'b0, accum_we | file_we | pc_load | busy | zero_flag);
        cmp_val("reset data", 15'h0, 15'(accum_data | file_wdata) | pc_target | 15'(file_waddr));
        {e_awe, e_fwe, e_zero, e_pcl, e_busy} = 5'h0;
        @(posedge clk_sys);
        nrst <= 1'b1;
    endtask

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence: random back-to-back traffic, one mid-run reset
    initial
    begin
        {nrst, clk_en, op_valid, dest_file, file_addr, pc_high_latch} = '0;
        {file_data, jump_literal} = '0;
        op = FXB_OP_NONE;
        fail_count = 0;
        comparisons = 0;
        void'($urandom(32'h30a5));
        do_reset(20);
        for (int i = 0; i < 4000; i++)
        begin
            @(posedge clk_sys);
            model_step();
            if (i < 6)
                drive_corner(i);
            else
                drive_random();
            #1;
            cmp_flag("accum_we", e_awe, accum_we);
            cmp_flag("file_we", e_fwe, file_we);
            cmp_flag("zero_flag", e_zero, zero_flag);
            cmp_flag("pc_load", e_pcl, pc_load);
            cmp_flag("busy", e_busy, busy);
            if (e_awe) cmp_val("accum_data", 15'(e_adata), 15'(accum_data));
            if (e_fwe) cmp_val("file_wdata", 15'(e_fdata), 15'(file_wdata));
            if (e_fwe) cmp_val("file_waddr", 15'(e_faddr), 15'(file_waddr));
            if (e_pcl) cmp_val("pc_target", e_pct, pc_target);
            if (i == 2000) do_reset(2);
        end
        final_report();
    end

    // Watchdog well past the expected run length
    initial
    begin
        #80000;
        fail_count++;
        final_report();
    end
endmodule
